// >>> rtl/nrp_map.svh
`ifndef NRP_MAP_SVH
`define NRP_MAP_SVH

// Geometry
`define NRP_NUM_REGS       4
`define NRP_MAIN_CHARS     16
`define NRP_STAT_CHARS     4
`define NRP_CELLS          80
`define NRP_CELLS_PER_REG  20
// Phase counter
`define NRP_PHASES         8
`define NRP_PH_A1          3'h0
`define NRP_PH_A2          3'h1
`define NRP_PH_A3          3'h2
`define NRP_PH_M1          3'h3
`define NRP_PH_M2          3'h4
`define NRP_PH_X1          3'h5
`define NRP_PH_X2          3'h6
`define NRP_PH_X3          3'h7
// Reset values
`define NRP_NIB_RST        4'h0
`define NRP_CHIP_RST       2'h0
// Operation nibble codes
`define NRP_OPC_WRITE_MAIN 4'h0
`define NRP_OPC_WRITE_PORT 4'h1
`define NRP_OPC_WSTAT_0    4'h4
`define NRP_OPC_WSTAT_1    4'h5
`define NRP_OPC_WSTAT_2    4'h6
`define NRP_OPC_WSTAT_3    4'h7
`define NRP_OPC_SUB_MEM    4'h8
`define NRP_OPC_READ_MAIN  4'h9
`define NRP_OPC_ADD_MEM    4'hB
`define NRP_OPC_RSTAT_0    4'hC
`define NRP_OPC_RSTAT_1    4'hD
`define NRP_OPC_RSTAT_2    4'hE
`define NRP_OPC_RSTAT_3    4'hF

`endif

// >>> rtl/nrp_pkg.sv
package nrp_pkg;

  // Operation decoded from the operation nibble
  typedef enum logic [2:0] {
    NRP_OP_NONE  = 3'b000,
    NRP_OP_RMAIN = 3'b001,
    NRP_OP_WMAIN = 3'b010,
    NRP_OP_RSTAT = 3'b011,
    NRP_OP_WSTAT = 3'b100,
    NRP_OP_WPORT = 3'b101
  } nrp_op_t;

  // Driven half of the two-way data bus: nibble and enable
  typedef struct packed {
    logic [3:0] dout;
    logic       oe;
  } nrp_bus_drv_t;

  // Selected address held after register-control transfer
  typedef struct packed {
    logic [1:0] reg_sel;
    logic [3:0] char_sel;
  } nrp_addr_t;

endpackage

// >>> rtl/nrp_ram_port.sv
`timescale 1ns/1ps
`include "nrp_map.svh"
module nrp_ram_port
  import nrp_pkg::*;
#(
  parameter bit OPTION_HIGH = 1'b0
) (
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [3:0] data_i,
  output logic      [3:0] data_o,
  output logic            data_oe_o,
  input  wire logic       sync_i,
  input  wire logic       ram_bank_select_line_i,
  input  wire logic       chip_strap_i,
  output logic      [3:0] port_o
);

  // ==========================================================
  // Pin synchronisers
  // Every pin but reset passes two flops, so the logic sees each slot two clocks late
  logic [3:0] d_s;
  logic       sync_s;
  logic       bank_s;
  logic       strap_s;

  // Bus nibble
  nrp_sync2 #(.W(4)) u_sync_data (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (data_i),
    .sync_o    (d_s)
  );

  // Cycle marker from the processor
  nrp_sync2 #(.W(1)) u_sync_mark (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (sync_i),
    .sync_o    (sync_s)
  );

  // Bank select line
  nrp_sync2 #(.W(1)) u_sync_bank (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (ram_bank_select_line_i),
    .sync_o    (bank_s)
  );

  // Chip number strap
  nrp_sync2 #(.W(1)) u_sync_strap (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (chip_strap_i),
    .sync_o    (strap_s)
  );

  // ==========================================================
  // Phase counter
  logic [2:0] phase_r;
  logic [2:0] phase_nxt;

  // Sync marks the last phase; next clock is the first address phase
  // Phases run behind the pins by the synchroniser delay, data alike
  always_comb begin
    if (sync_s) begin
      phase_nxt = `NRP_PH_A1;
    end else begin
      phase_nxt = phase_r + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_r <= `NRP_PH_X3;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // One strobe per phase: three address, two memory, three execute
  logic [`NRP_PHASES-1:0] phase_stb;

  always_comb begin
    phase_stb          = '0;
    phase_stb[phase_r] = 1'b1;
  end

  // ==========================================================
  // Chip number, caught on each clock from the synchronised strap
  logic [1:0] chip_num;
  logic       chip_hit;
  assign chip_num = {OPTION_HIGH, strap_s};
  // First register-control nibble names this chip in its two high bits
  assign chip_hit = (d_s[3:2] == chip_num);

  // ==========================================================
  // Control state: selection, address, decoded operation
  logic      sel_r;
  logic      sel_nxt;
  nrp_addr_t addr_r;
  nrp_addr_t addr_nxt;
  nrp_op_t   op_r;
  nrp_op_t   op_nxt;
  logic [1:0] stat_idx_r;
  logic [1:0] stat_idx_nxt;
  logic       pend_r;
  logic       pend_nxt;

  // Decode of the operation nibble on the bus
  nrp_op_t    op_dec;

  always_comb begin
    unique case (d_s)
      `NRP_OPC_WRITE_MAIN: op_dec = NRP_OP_WMAIN;
      `NRP_OPC_WRITE_PORT: op_dec = NRP_OP_WPORT;
      `NRP_OPC_SUB_MEM,
      `NRP_OPC_READ_MAIN,
      `NRP_OPC_ADD_MEM:    op_dec = NRP_OP_RMAIN;
      `NRP_OPC_WSTAT_0,
      `NRP_OPC_WSTAT_1,
      `NRP_OPC_WSTAT_2,
      `NRP_OPC_WSTAT_3:    op_dec = NRP_OP_WSTAT;
      `NRP_OPC_RSTAT_0,
      `NRP_OPC_RSTAT_1,
      `NRP_OPC_RSTAT_2,
      `NRP_OPC_RSTAT_3:    op_dec = NRP_OP_RSTAT;
      default:             op_dec = NRP_OP_NONE; // Unused codes do nothing
    endcase
  end

  always_comb begin
    sel_nxt      = sel_r;
    addr_nxt     = addr_r;
    op_nxt       = op_r;
    stat_idx_nxt = stat_idx_r;
    pend_nxt     = pend_r;
    unique case (phase_r)
      `NRP_PH_M2: begin
        // Operation nibble captured under bank select
        if (bank_s && sel_r) begin
          op_nxt       = op_dec;
          stat_idx_nxt = d_s[1:0];
        end else begin
          op_nxt = NRP_OP_NONE;
        end
        pend_nxt = 1'b0;
      end
      `NRP_PH_X2: begin
        // Bank select at X2: register-control first nibble
        if (bank_s) begin
          pend_nxt = chip_hit;
          if (chip_hit) begin
            addr_nxt.reg_sel = d_s[1:0];
          end else begin
            sel_nxt = 1'b0; // Another chip on this bank was chosen
          end
        end
      end
      `NRP_PH_X3: begin
        // Second nibble completes the selection
        if (pend_r) begin
          addr_nxt.char_sel = d_s;
          sel_nxt           = 1'b1;
        end
        pend_nxt = 1'b0;
        op_nxt   = NRP_OP_NONE;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_r      <= 1'b0;
      addr_r     <= '0;
      op_r       <= NRP_OP_NONE;
      stat_idx_r <= `NRP_CHIP_RST;
      pend_r     <= 1'b0;
    end else begin
      sel_r      <= sel_nxt;
      addr_r     <= addr_nxt;
      op_r       <= op_nxt;
      stat_idx_r <= stat_idx_nxt;
      pend_r     <= pend_nxt;
    end
  end

  // ==========================================================
  // Memory: per register 16 main cells then 4 status cells
  logic [3:0] mem_r [`NRP_CELLS];
  logic [6:0] clr_r;
  logic [6:0] clr_nxt;
  logic [6:0] main_idx;
  logic [6:0] stat_idx;
  logic [6:0] acc_idx;
  logic       wr_en;
  logic [3:0] rd_data;

  assign main_idx = 7'(addr_r.reg_sel * `NRP_CELLS_PER_REG) + {3'h0, addr_r.char_sel};
  assign stat_idx = 7'(addr_r.reg_sel * `NRP_CELLS_PER_REG)
                  + 7'(`NRP_MAIN_CHARS) + {5'h0, stat_idx_r};
  assign acc_idx  = (op_r == NRP_OP_RSTAT || op_r == NRP_OP_WSTAT) ? stat_idx : main_idx;
  assign wr_en    = phase_stb[`NRP_PH_X2] && (op_r == NRP_OP_WMAIN || op_r == NRP_OP_WSTAT);
  assign rd_data  = mem_r[acc_idx];

  // Refresh counter runs free with no reset, so it walks the array while
  // reset is held; any start value out of range falls back to cell zero
  always_comb begin
    if (clr_r < 7'(`NRP_CELLS - 1)) begin
      clr_nxt = clr_r + 7'h01;
    end else begin
      clr_nxt = 7'h00;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    clr_r <= clr_nxt;
  end

  // Array cells: cleared by scan in reset, else written at X2
  // Reset is read here as a level; the cells carry no reset of their own
  always_ff @(posedge sys_clk_i) begin
    if (!arst_n_i) begin
      mem_r[clr_r] <= `NRP_NIB_RST;
    end else if (wr_en) begin
      mem_r[acc_idx] <= d_s;
    end
  end

  // ==========================================================
  // Output port
  logic [3:0] port_r;
  logic [3:0] port_nxt;

  always_comb begin
    if (phase_stb[`NRP_PH_X2] && op_r == NRP_OP_WPORT) begin
      port_nxt = d_s;
    end else begin
      port_nxt = port_r;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_r <= `NRP_NIB_RST;
    end else begin
      port_r <= port_nxt;
    end
  end

  assign port_o = port_r;

  // ==========================================================
  // Bus driver: read data during X2 only, off elsewhere
  // The answer stands in the device's own X2, behind the pins by the sync delay
  nrp_bus_drv_t drv_r;
  nrp_bus_drv_t drv_nxt;

  always_comb begin
    drv_nxt.dout = `NRP_NIB_RST;
    drv_nxt.oe   = 1'b0;
    if (phase_nxt == `NRP_PH_X2 && (op_r == NRP_OP_RMAIN || op_r == NRP_OP_RSTAT)) begin
      drv_nxt.dout = rd_data;
      drv_nxt.oe   = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drv_r <= '0;
    end else begin
      drv_r <= drv_nxt;
    end
  end

  assign data_o    = drv_r.dout;
  assign data_oe_o = drv_r.oe & arst_n_i;

endmodule // nrp_ram_port

// >>> rtl/nrp_sync2.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a bundle of pin levels
module nrp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // ==========================================================
  // Chain of two registers
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule // nrp_sync2

// >>> test/nrp_cpu_model.sv
`timescale 1ns/1ps
// ============================================================
// Processor side: one bus slot per clock, sync in the last slot
module nrp_cpu_model (
  input  wire logic       sys_clk_i,
  output logic            sync_o,
  output logic            bank_o,
  output logic [3:0]      dat_o,
  output logic            dat_oe_o
);
  // Quiet pins at time zero
  initial begin
    sync_o = 1'b0;
    bank_o = 1'b0;
    dat_o = 4'h0;
    dat_oe_o = 1'b0;
  end
  // Drive one slot just after the edge and hold it for the whole clock
  task automatic slot(input logic s, input logic b, input logic oe, input logic [3:0] d);
    @(posedge sys_clk_i);
    #2;
    sync_o = s;
    bank_o = b;
    dat_oe_o = oe;
    dat_o = d;
  endtask
  // Slots A1-A3, M1, M2, X1, X2, X3; the bus is let go at X1
  task automatic cyc(input logic bm2, input logic [3:0] operation_nibble, input logic bx2,
                     input logic wx2, input logic [3:0] x2, input logic [3:0] x3);
    for (int i = 0; i < 4; i++) begin
      slot(1'b0, 1'b0, 1'b1, 4'(i));
    end
    slot(1'b0, bm2, 1'b1, operation_nibble);
    slot(1'b0, 1'b0, 1'b0, 4'h0);
    slot(1'b0, bx2, wx2, x2);
    slot(1'b1, 1'b0, 1'b1, x3);
  endtask
endmodule  // nrp_cpu_model

// >>> test/nrp_ram_port_props.sv
`timescale 1ns/1ps
// ============================================================
// Port-level checks of the nibble RAM and port
module nrp_ram_port_props (
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [3:0] data_i,
  input  wire logic [3:0] data_o,
  input  wire logic       data_oe_o,
  input  wire logic       sync_i,
  input  wire logic       ram_bank_select_line_i,
  input  wire logic       chip_strap_i,
  input  wire logic [3:0] port_o
);
  logic [3:0] sync_age_r, sync_age_nxt;
  logic [3:0] bank_age_r, bank_age_nxt;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Clocks since the last sync and bank select, saturating at 15
  always_comb begin
    sync_age_nxt = sync_i ? 4'h0 : sync_age_r + {3'h0, sync_age_r != 4'hF};
    bank_age_nxt = ram_bank_select_line_i ? 4'h0 : bank_age_r + {3'h0, bank_age_r != 4'hF};
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_age_r <= 4'hF;
      bank_age_r <= 4'hF;
    end else begin
      sync_age_r <= sync_age_nxt;
      bank_age_r <= bank_age_nxt;
    end
  end

  // A read answer and the quiet rest of its instruction cycle
  sequence s_drive_start;
    $rose(data_oe_o);
  endsequence
  sequence s_quiet_rest;
    !data_oe_o [*7];
  endsequence

  chk_rst_float: assert property ($rose(arst_n_i) |-> !data_oe_o)
    else $error("data bus driven at reset release");
  chk_rst_port: assert property ($rose(arst_n_i) |-> port_o == 4'h0)
    else $error("output port not cleared by reset");
  chk_oe_pulse: assert property (data_oe_o |=> !data_oe_o)
    else $error("data bus not released after one clock");
  chk_oe_spacing: assert property (s_drive_start |=> s_quiet_rest)
    else $error("two answers within one instruction cycle");
  chk_oe_in_frame: assert property (data_oe_o |-> sync_age_r < 4'h8)
    else $error("answer without a running instruction cycle");
  chk_oe_after_op: assert property (data_oe_o |-> bank_age_r < 4'hF)
    else $error("answer without an operation nibble");
  chk_port_hold: assert property (!$stable(port_o) |=> $stable(port_o) [*7])
    else $error("output port changed twice in one cycle");
  chk_port_cause: assert property (!$stable(port_o) |-> bank_age_r < 4'hF && !data_oe_o)
    else $error("output port changed without a port write");
endmodule  // nrp_ram_port_props

bind nrp_ram_port nrp_ram_port_props u_props (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .data_i(data_i), .data_o(data_o),
  .data_oe_o(data_oe_o), .sync_i(sync_i), .ram_bank_select_line_i(ram_bank_select_line_i),
  .chip_strap_i(chip_strap_i), .port_o(port_o));

// >>> test/tb.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the nibble RAM and port
module tb;
  logic       sys_clk, arst_n, strap, dut_oe, cpu_oe, sync, bank;
  logic [3:0] bus, dut_d, cpu_d, port;
  logic [3:0] last_r = 4'h0;
  logic [3:0] mem [4][20];
  logic [1:0] ra [12];
  logic [3:0] ca [12];
  logic [3:0] exp_q [$];
  logic [3:0] rd_ops [3] = '{4'h9, 4'hB, 4'h8};
  int         err_count, checks_done, seed, rnd;

  // ============================================================
  // Clock, wire and instances
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Released bus shows a value that flips every clock
  assign bus = dut_oe ? dut_d : (cpu_oe ? cpu_d : ~last_r);
  always @(posedge sys_clk) last_r <= bus;
  nrp_ram_port #(.OPTION_HIGH(1'b1)) u_dut (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .data_i(bus), .data_o(dut_d),
    .data_oe_o(dut_oe), .sync_i(sync), .ram_bank_select_line_i(bank),
    .chip_strap_i(strap), .port_o(port));
  nrp_cpu_model u_cpu (.sys_clk_i(sys_clk), .sync_o(sync), .bank_o(bank),
    .dat_o(cpu_d), .dat_oe_o(cpu_oe));

  // ============================================================
  // Checking and bus tasks
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic sel_reg(input logic [1:0] chip, input logic [1:0] r, input logic [3:0] c);
    u_cpu.cyc(1'b0, 4'h0, 1'b1, 1'b1, {chip, r}, c);
  endtask
  task automatic op(input logic [3:0] operation_nibble, input logic [3:0] d);
    u_cpu.cyc(1'b1, operation_nibble, 1'b0, ~operation_nibble[3], d, 4'h0);
  endtask
  task automatic rd(input logic [3:0] operation_nibble, input logic [3:0] e);
    exp_q.push_back(e);
    op(operation_nibble, 4'h0);
  endtask
  // Each answer on the bus is matched against the oldest note, mid-clock
  always @(negedge sys_clk) begin
    if (dut_oe === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected drive", 4'h1, 4'h0);
      else chk("read data", dut_d, exp_q.pop_front());
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    end_of_test();
  end

  // ============================================================
  // Main sequence
  initial begin
    seed = 32'h6692_f553;
    err_count = 0;
    checks_done = 0;
    arst_n = 1'b0;
    strap = 1'b0;
    repeat (256) @(posedge sys_clk);
    #2 arst_n = 1'b1;
    u_cpu.cyc(1'b0, 4'h0, 1'b0, 1'b0, 4'h0, 4'h0);
    sel_reg(2'b10, 2'h3, 4'hF);
    rd(4'h9, 4'h0);
    rd(4'hF, 4'h0);
    // Random main writes, read back by every main-read code, then again
    for (int k = 0; k < 12; k++) begin
      rnd = $random(seed);
      ra[k] = rnd[1:0];
      ca[k] = rnd[5:2];
      mem[ra[k]][ca[k]] = rnd[9:6];
      sel_reg({1'b1, strap}, ra[k], ca[k]);
      op(4'h0, rnd[9:6]);
    end
    for (int k = 0; k < 24; k++) begin
      sel_reg({1'b1, strap}, ra[k % 12], ca[k % 12]);
      rd(k < 12 ? rd_ops[k % 3] : 4'h9, mem[ra[k % 12]][ca[k % 12]]);
    end
    // Status characters of one register, then the port
    rnd = $random(seed);
    sel_reg({1'b1, strap}, rnd[1:0], rnd[5:2]);
    for (int s = 0; s < 4; s++) begin
      mem[rnd[1:0]][16 + s] = rnd[9:6] ^ s[3:0];
      op(4'h4 + s[3:0], mem[rnd[1:0]][16 + s]);
    end
    for (int s = 0; s < 4; s++) rd(4'hC + s[3:0], mem[rnd[1:0]][16 + s]);
    op(4'h1, rnd[13:10]);
    u_cpu.cyc(1'b0, 4'h0, 1'b0, 1'b0, 4'h0, 4'h0);
    chk("port", port, rnd[13:10]);
    // Strap change moves the chip number; the old number is ignored
    strap = 1'b1;
    u_cpu.cyc(1'b0, 4'h0, 1'b0, 1'b0, 4'h0, 4'h0);
    sel_reg(2'b10, ra[0], ca[0]);
    op(4'h0, ~mem[ra[0]][ca[0]]);
    op(4'h1, ~rnd[13:10]);
    op(4'h9, 4'h0);
    sel_reg(2'b11, ra[0], ca[0]);
    rd(4'h9, mem[ra[0]][ca[0]]);
    u_cpu.cyc(1'b0, 4'h0, 1'b0, 1'b0, 4'h0, 4'h0);
    chk("port held", port, rnd[13:10]);
    // Reset in mid-run clears port and memory
    u_cpu.slot(1'b0, 1'b0, 1'b0, 4'h0);
    arst_n = 1'b0;
    repeat (256) @(posedge sys_clk);
    #2 arst_n = 1'b1;
    chk("port after reset", port, 4'h0);
    u_cpu.cyc(1'b0, 4'h0, 1'b0, 1'b0, 4'h0, 4'h0);
    sel_reg(2'b11, ra[0], ca[0]);
    rd(4'h9, 4'h0);
    rd(4'hC, 4'h0);
    for (int i = 0; i < 40 && exp_q.size() != 0; i++) @(posedge sys_clk);
    chk("answers left", 4'(exp_q.size()), 4'h0);
    end_of_test();
  end
endmodule  // tb
